//--- hw/irq_bank_regs.vh
`ifndef IRQ_BANK_REGS_VH
`define IRQ_BANK_REGS_VH

// Register offsets on the control interface
`define CLOCK_FLAGS_OFFSET      16'h0D02
`define ERROR_FLAGS_OFFSET      16'h0D03
`define COMPLETION_FLAGS_OFFSET 16'h0D04
`define MASK_BANK_OFFSET        16'h0D08
`define MASK_BANK_LAST          16'h0D0C
`define STATE_OFFSET            16'h0D0E
`define GLOBAL_MASK_OFFSET      16'h0D0F
`define PIN_FLAGS_OFFSET        16'h0D10
`define EDGE_FLAGS_OFFSET       16'h0D51
`define EDGE_MASKS_OFFSET       16'h0D53
`define PIN_CTRL_OFFSET         16'h0C0F

// Field positions
`define GLOBAL_MASK_BIT   0
`define STATE_BIT         0
`define POLARITY_BIT      10
`define STARTUP_BIT       8

// Edge selection per flag register: a one arms that edge for that bit
`define CLOCK_RISE        16'h000F
`define CLOCK_FALL        16'h000C
`define ERROR_RISE        16'hFCC0
`define ERROR_FALL        16'h0300
`define COMPLETION_RISE   16'h01C3
`define COMPLETION_FALL   16'h0003
`define EDGE_RISE         16'h0054
`define EDGE_FALL         16'h00A8
`define PIN_RISE          16'h000F
`define PIN_FALL          16'h000F

// Reset values
`define MASK_RESET        16'hFFFF
`define COMPLETION_MASK_RESET 16'hFEFF
`define EDGE_MASK_RESET   16'h00FC
`define EDGE_MASK_BITS    16'h00FC
`define GLOBAL_MASK_RESET 1'b0
`define POLARITY_RESET    1'b1

`endif

//--- hw/pin_sync.v
// Two-stage synchroniser for levels arriving from device pins
module pin_sync #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;  // Metastable stage, read only by sync_out

  // First stage feeds only the second one
  always @(posedge mclk) begin
    if (reset) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

//--- hw/edge_flag.v
// One sticky event flag: set on the armed edge(s), cleared by a write of one
module edge_flag #(
  parameter [0:0] RISE = 1'b1,
  parameter [0:0] FALL = 1'b0
) (
  // Clock and reset
  input  wire mclk,
  input  wire reset,
  // Event source and clear strobe
  input  wire level,
  input  wire clear,
  // Sticky flag
  output reg  flag
);

  reg  prev;  // Level seen on the previous edge
  wire hit;   // Armed edge seen this cycle

  assign hit = (RISE & level & ~prev) | (FALL & ~level & prev);

  // Set wins over a clear in the same cycle so no event is lost
  always @(posedge mclk) begin
    if (reset) begin
      prev <= 1'b0;
      flag <= 1'b0;
    end else begin
      prev <= level;
      flag <= hit | (flag & ~clear);  // RL1
    end
  end

endmodule

//--- hw/irq_status_mask_bank.v
`include "irq_bank_regs.vh"

// Behaviour
// RL1 - Flags sticky; write one clears; reset zero
// RL2 - Lock and clock-good flags on both edges
// RL3 - Main clock underrate flag on rising edge
// RL4 - Aux clock underrate flag on rising edge
// RL5 - Rate converter config error, bit fifteen
// RL6 - Three serial port config error flags
// RL7 - Host port error flag at bit eleven
// RL8 - Mixer sample loss flag at bit ten
// RL9 - Aux clock stop flag on enable fall
// RL10 - Main clock stop flag on enable fall
// RL11 - Two iso converter config error flags
// RL12 - Offset trim done flags on rising edge
// RL13 - Parallel mask bank; one suppresses flag
// RL14 - Startup mask resets zero, others one
// RL15 - Global output mask bit zero, reset zero
// RL16 - Separate rise and fall always-on flags
// RL17 - Always-on masks, reset one, one suppresses
// RL18 - Second output pin flags, both edges
// RL19 - Pin active low by default, polarity bit
// RL20 - Combined output state readable
// RL21 - Output asserts on any unmasked flag
// RL22 - Host reads, services, writes ones back
module irq_status_mask_bank (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Control interface register port
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Clock generator conditions
  input  wire        loop1_lock,
  input  wire        loop2_lock,
  input  wire        loop1_clock_good,
  input  wire        loop2_clock_good,
  input  wire        main_clock_underrate,
  input  wire        aux_clock_underrate,
  input  wire        main_clock_enable,
  input  wire        aux_clock_enable,
  // Configuration and datapath errors
  input  wire        async_rate_conv_cfg_error,
  input  wire        serial_port1_cfg_error,
  input  wire        serial_port2_cfg_error,
  input  wire        serial_port3_cfg_error,
  input  wire        host_port_error_event,
  input  wire        mixer_sample_loss_event,
  input  wire        iso_rate_conv1_cfg_error,
  input  wire        iso_rate_conv2_cfg_error,
  // Completion conditions
  input  wire        startup_complete_event,
  input  wire        offset_trim_dac_done,
  input  wire        offset_trim_phones_done,
  // Pin levels, asynchronous to mclk
  input  wire        mic_clamp_pin,
  input  wire        pin5_level,
  input  wire        jack_sense_pin,
  input  wire [3:0]  pin_levels,
  // Interrupt pin
  output reg         irq_pin
);

  // Flag registers, in generate order; five words live in this bank.
  // Bits with neither edge armed get no flip-flop and read zero.
  // Offsets, rise and fall arms: lowest word on the right
  localparam NREG = 5;
  localparam [NREG*16-1:0] OFF_ALL = {
    `PIN_FLAGS_OFFSET, `EDGE_FLAGS_OFFSET, `COMPLETION_FLAGS_OFFSET,
    `ERROR_FLAGS_OFFSET, `CLOCK_FLAGS_OFFSET};
  localparam [NREG*16-1:0] RISE_ALL = {
    `PIN_RISE, `EDGE_RISE, `COMPLETION_RISE, `ERROR_RISE, `CLOCK_RISE};
  localparam [NREG*16-1:0] FALL_ALL = {
    `PIN_FALL, `EDGE_FALL, `COMPLETION_FALL, `ERROR_FALL, `CLOCK_FALL};

  // Address match, shared by the clear path and the mask and control write paths
  // Full sixteen-bit compare, so nearby offsets never alias
  function addr_hit;
    input [15:0] addr;
    input [15:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // Mask bank window, shared by the write and read paths
  function in_mask_bank;
    input [15:0] addr;
    begin
      in_mask_bank = (addr >= `MASK_BANK_OFFSET) && (addr <= `MASK_BANK_LAST);
    end
  endfunction

  // Word index inside the mask bank; meaningless outside the window,
  // so callers always test in_mask_bank first
  function [2:0] mask_index;
    input [15:0] addr;
    reg   [15:0] delta;
    begin
      delta      = addr - `MASK_BANK_OFFSET;
      mask_index = delta[2:0];
    end
  endfunction

  // Source and flag plumbing
  wire [6:0]       pins_sync;   // Synchronised pin levels
  wire [15:0]      clock_lvl;   // Sources of the clock flags
  wire [15:0]      error_lvl;   // Sources of the error flags
  wire [15:0]      done_lvl;    // Sources of the completion flags
  wire [15:0]      edge_lvl;    // Sources of the always-on flags
  wire [15:0]      pin_lvl;     // Sources of the second output's pin flags
  wire [NREG*16-1:0] level_all; // All sources, one word per register
  wire [NREG*16-1:0] clear_all; // Write-one-to-clear strobes
  wire [NREG*16-1:0] flag_all;  // All sticky flags
  reg  [15:0]      mask_bank [0:4];  // Per-flag masks, one per status word
  reg  [15:0]      edge_mask;   // Always-on masks
  reg              global_mask; // Output gate
  reg              polarity;    // One drives the pin active low
  reg              irq_active;  // Combined output state
  wire             next_active; // Unmasked flag present
  // Flag words as the host reads them
  wire [15:0]      clock_flags; // Clock generator word
  wire [15:0]      error_flags; // Error word
  wire [15:0]      done_flags;  // Completion word
  wire [15:0]      edge_flags;  // Always-on word
  wire [15:0]      pin_flags;   // Second output's pin word
  integer          i;           // Reset loop index for the mask bank

  // Pins cross into mclk before any edge detector sees them
  // Edge history resets to zero, so a pin already high at release
  // reports one rise shortly after reset
  pin_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .mclk    (mclk),
    .reset   (reset),
    .async_in({mic_clamp_pin, pin5_level, jack_sense_pin, pin_levels}),
    .sync_out(pins_sync)
  );

  // Clock word: lock flags on both edges, underrate on rise
  assign clock_lvl = {12'h000, loop2_lock, loop1_lock,      // RL2
                      main_clock_underrate,                 // RL3
                      aux_clock_underrate};                 // RL4

  // Error word; stop flags watch the enables fall
  // Bits five to zero have no source in this word
  assign error_lvl = {async_rate_conv_cfg_error,            // RL5
                      serial_port3_cfg_error,               // RL6
                      serial_port2_cfg_error,
                      serial_port1_cfg_error,
                      host_port_error_event,                // RL7
                      mixer_sample_loss_event,              // RL8
                      aux_clock_enable,                     // RL9
                      main_clock_enable,                    // RL10
                      iso_rate_conv1_cfg_error,             // RL11
                      iso_rate_conv2_cfg_error,
                      6'h00};

  // Completion word
  // Clock-good sources share this word with the completion events
  assign done_lvl = {7'h00, startup_complete_event,
                     offset_trim_dac_done,                  // RL12
                     offset_trim_phones_done,
                     4'h0, loop2_clock_good, loop1_clock_good}; // RL2

  // Each always-on source feeds a fall flag and a rise flag
  assign edge_lvl = {8'h00, pins_sync[6], pins_sync[6],     // RL16
                     pins_sync[5], pins_sync[5],
                     pins_sync[4], pins_sync[4], 2'b00};

  // Second output's pin flags, both edges
  assign pin_lvl = {12'h000, pins_sync[3:0]};               // RL18

  // All source words, lowest register on the right
  assign level_all = {pin_lvl, edge_lvl, done_lvl, error_lvl, clock_lvl};

  // One sticky flag per armed bit; unarmed bits read zero
  // A clear strobe only reaches bits written as one
  genvar r, b;
  generate
    for (r = 0; r < NREG; r = r + 1) begin : g_reg
      for (b = 0; b < 16; b = b + 1) begin : g_bit
        assign clear_all[r*16+b] = reg_wr & reg_wdata[b] &
                                   addr_hit(reg_addr, OFF_ALL[r*16 +: 16]); // RL1
        if (RISE_ALL[r*16+b] | FALL_ALL[r*16+b]) begin : g_flag
          edge_flag #(
            .RISE(RISE_ALL[r*16+b]),
            .FALL(FALL_ALL[r*16+b])
          ) u_flag (
            .mclk (mclk),
            .reset(reset),
            .level(level_all[r*16+b]),
            .clear(clear_all[r*16+b]),
            .flag (flag_all[r*16+b])
          );
        end else begin : g_none
          assign flag_all[r*16+b] = 1'b0;
        end
      end
    end
  endgenerate

  // Slice the flag vector back into host words
  assign clock_flags = flag_all[15:0];
  assign error_flags = flag_all[31:16];
  assign done_flags  = flag_all[47:32];
  assign edge_flags  = flag_all[63:48];
  assign pin_flags   = flag_all[79:64];

  // Mask bank: five words, masks for words outside this block kept too.
  // One process owns the whole array so each word has a single driver.
  always @(posedge mclk) begin
    if (reset) begin
      for (i = 0; i < 4; i = i + 1) begin
        mask_bank[i] <= `MASK_RESET;  // RL14
      end
      // Only the startup mask comes up open
      mask_bank[4] <= `COMPLETION_MASK_RESET;  // RL14
    end else if (reg_wr && in_mask_bank(reg_addr)) begin
      mask_bank[mask_index(reg_addr)] <= reg_wdata;  // RL13
    end
  end

  // Always-on masks; only bits with a flag behind them are stored
  // Unused low bits and the upper byte read zero
  always @(posedge mclk) begin
    if (reset) begin
      edge_mask <= `EDGE_MASK_RESET;  // RL17
    end else if (reg_wr && addr_hit(reg_addr, `EDGE_MASKS_OFFSET)) begin
      edge_mask <= reg_wdata & `EDGE_MASK_BITS;  // RL17
    end
  end

  // Global mask and pin polarity
  // Polarity lives in the pin control word outside this bank;
  // each bit changes only on a write to its own offset
  always @(posedge mclk) begin
    if (reset) begin
      global_mask <= `GLOBAL_MASK_RESET;  // RL15
      polarity    <= `POLARITY_RESET;     // RL19
    end else begin
      if (reg_wr && addr_hit(reg_addr, `GLOBAL_MASK_OFFSET)) begin
        global_mask <= reg_wdata[`GLOBAL_MASK_BIT];  // RL15
      end
      if (reg_wr && addr_hit(reg_addr, `PIN_CTRL_OFFSET)) begin
        polarity <= reg_wdata[`POLARITY_BIT];  // RL19
      end
    end
  end

  // Any flag with its mask open raises the output unless gated globally
  // Pin flags belong to the second output and never reach this pin
  assign next_active = ~global_mask &                        // RL15
                       (|(clock_flags & ~mask_bank[2]) |     // RL13
                        |(error_flags & ~mask_bank[3]) |
                        |(done_flags  & ~mask_bank[4]) |
                        |(edge_flags  & ~edge_mask));        // RL17

  // Combined state is registered, then the pin one cycle later
  // The extra stage costs a cycle but keeps OR-tree glitches off the pad
  always @(posedge mclk) begin
    if (reset) begin
      irq_active <= 1'b0;
      irq_pin    <= `POLARITY_RESET;  // Idle level for active low
    end else begin
      irq_active <= next_active;            // RL21
      irq_pin    <= irq_active ^ polarity;  // RL19
    end
  end

  // Register read; unmapped addresses read zero
  // Reads are registered; data holds until the next read
  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CLOCK_FLAGS_OFFSET:      reg_rdata <= clock_flags;
        `ERROR_FLAGS_OFFSET:      reg_rdata <= error_flags;
        `COMPLETION_FLAGS_OFFSET: reg_rdata <= done_flags;
        // Combined state shows the gated output level
        `STATE_OFFSET:            reg_rdata <= {15'h0000, irq_active}; // RL20
        `GLOBAL_MASK_OFFSET:      reg_rdata <= {15'h0000, global_mask};
        `PIN_FLAGS_OFFSET:        reg_rdata <= pin_flags;
        `EDGE_FLAGS_OFFSET:       reg_rdata <= edge_flags;
        `EDGE_MASKS_OFFSET:       reg_rdata <= edge_mask;
        `PIN_CTRL_OFFSET:         reg_rdata <= {5'h00, polarity, 10'h000};
        // Mask words are decoded by window, not one label each
        default: begin
          if (in_mask_bank(reg_addr)) begin
            reg_rdata <= mask_bank[mask_index(reg_addr)];  // RL13
          end else begin
            reg_rdata <= 16'h0000;  // Unmapped and gaps read zero
          end
        end
      endcase
    end
  end

endmodule

//--- tb/irq_bank_properties.sv
// Watches the register port and the pin of the interrupt bank
module irq_bank_checker (
  // Clock and reset
  input wire        mclk,
  input wire        reset,
  // Register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // Pin
  input wire        irq_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Host sets the global output mask
  sequence gm_set;
    reg_wr && reg_addr == 16'h0D0F && reg_wdata[0];
  endsequence
  // Write, one idle cycle, then a read of the same place
  sequence wr_rd(a);
    reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a && !reg_wr;
  endsequence
  // Read back keeps only the implemented bits
  property rw_back(a, m);
    wr_rd(a) |=> reg_rdata == ($past(reg_wdata, 3) & m);
  endproperty
  a_reset_pin_idle: assert property ($fell(reset) |-> irq_pin && reg_rdata == 16'h0000)
    else $error("pin or read data not idle after reset");
  a_read_data_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr == 16'h0D0D |=> reg_rdata == 16'h0000)
    else $error("gap in mask bank read nonzero");
  a_mask_bank_rw: assert property (rw_back(16'h0D0B, 16'hFFFF))
    else $error("mask bank read back differs");
  a_edge_mask_rw: assert property (rw_back(16'h0D53, 16'h00FC))
    else $error("always-on mask read back differs");
  a_global_mask_rw: assert property (rw_back(16'h0D0F, 16'h0001))
    else $error("global mask read back differs");
  a_state_gated_off: assert property (gm_set ##1 !reg_wr ##1 reg_rd && reg_addr == 16'h0D0E
    |=> reg_rdata == 16'h0000)
    else $error("combined state visible while masked");
  a_masked_pin_still: assert property (gm_set ##1 (!reg_wr)[*4] |-> $stable(irq_pin))
    else $error("pin moved under global mask");
endmodule

bind irq_status_mask_bank irq_bank_checker irq_bank_checker_i (.*);

//--- tb/irq_host_model.sv
// Host side of the register port; strobes last exactly one edge
module irq_host_model (
  // Clock
  input  wire        mclk,
  // Register port
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  wire  [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data is registered on the taking edge, so look just after it
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Clear exactly the flags that were seen set
  task automatic service(input logic [15:0] a);
    logic [15:0] f;
    rd(a, f);
    wr(a, f);
  endtask
endmodule

//--- tb/irq_status_mask_bank_tb_top.sv
module irq_status_mask_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [15:0] r; logic [15:0] f;} row_t;
  logic        mclk;
  logic        reset;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, v;
  logic        reg_wr, reg_rd, irq_pin;
  logic [25:0] s;      // Event sources, one per table row
  int          err_count, compares, cycles;
  // Flag register low byte, flags after a rise, flags after a fall
  row_t        rows [26] = '{
    '{8'h02, 16'h0004, 16'h0004}, '{8'h02, 16'h0008, 16'h0008},
    '{8'h04, 16'h0001, 16'h0001}, '{8'h04, 16'h0002, 16'h0002},
    '{8'h02, 16'h0002, 16'h0000}, '{8'h02, 16'h0001, 16'h0000},
    '{8'h03, 16'h0000, 16'h0100}, '{8'h03, 16'h0000, 16'h0200},
    '{8'h03, 16'h8000, 16'h0000}, '{8'h03, 16'h1000, 16'h0000},
    '{8'h03, 16'h2000, 16'h0000}, '{8'h03, 16'h4000, 16'h0000},
    '{8'h03, 16'h0800, 16'h0000}, '{8'h03, 16'h0400, 16'h0000},
    '{8'h03, 16'h0080, 16'h0000}, '{8'h03, 16'h0040, 16'h0000},
    '{8'h04, 16'h0100, 16'h0000}, '{8'h04, 16'h0080, 16'h0000},
    '{8'h04, 16'h0040, 16'h0000}, '{8'h51, 16'h0040, 16'h0080},
    '{8'h51, 16'h0010, 16'h0020}, '{8'h51, 16'h0004, 16'h0008},
    '{8'h10, 16'h0001, 16'h0001}, '{8'h10, 16'h0002, 16'h0002},
    '{8'h10, 16'h0004, 16'h0004}, '{8'h10, 16'h0008, 16'h0008}};

  irq_status_mask_bank irq_status_mask_bank_i (
    .*,
    .loop1_lock(s[0]), .loop2_lock(s[1]), .loop1_clock_good(s[2]),
    .loop2_clock_good(s[3]), .main_clock_underrate(s[4]), .aux_clock_underrate(s[5]),
    .main_clock_enable(s[6]), .aux_clock_enable(s[7]), .async_rate_conv_cfg_error(s[8]),
    .serial_port1_cfg_error(s[9]), .serial_port2_cfg_error(s[10]),
    .serial_port3_cfg_error(s[11]), .host_port_error_event(s[12]),
    .mixer_sample_loss_event(s[13]), .iso_rate_conv1_cfg_error(s[14]),
    .iso_rate_conv2_cfg_error(s[15]), .startup_complete_event(s[16]),
    .offset_trim_dac_done(s[17]), .offset_trim_phones_done(s[18]),
    .mic_clamp_pin(s[19]), .pin5_level(s[20]), .jack_sense_pin(s[21]),
    .pin_levels(s[25:22]));
  irq_host_model irq_host_model_i (.*);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    irq_host_model_i.rd(a, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    irq_host_model_i.wr(a, d);
  endtask
  // Pins need two sync stages plus flag, state and pin registers
  task automatic step(input int i, input logic b);
    @(posedge mclk);
    s[i] <= b;
    repeat (6) @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard, far beyond the expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end

  initial begin
    reset = 1'b1;
    s = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(16'h0D08 + i, 16'hFFFF);
    rd_chk(16'h0D0C, 16'hFEFF);
    rd_chk(16'h0D53, 16'h00FC);
    rd_chk(16'h0D0F, 16'h0000);
    // Only the startup flag reaches the pin out of reset
    step(16, 1'b1);
    chk({15'h0000, irq_pin}, 16'h0000);
    rd_chk(16'h0D0E, 16'h0001);
    wr(16'h0D0F, 16'h0001);
    rd_chk(16'h0D0F, 16'h0001);
    wr(16'h0D0F, 16'h0001);
    rd_chk(16'h0D0E, 16'h0000);
    step(16, 1'b0);
    chk({15'h0000, irq_pin}, 16'h0001);
    wr(16'h0D0F, 16'h0000);
    wr(16'h0C0F, 16'h0000);
    step(16, 1'b0);
    chk({15'h0000, irq_pin}, 16'h0001);
    wr(16'h0C0F, 16'h0400);
    wr(16'h0D04, 16'h0000);
    rd_chk(16'h0D04, 16'h0100);
    wr(16'h0D04, 16'h0100);
    step(16, 1'b0);
    chk({15'h0000, irq_pin}, 16'h0001);
    // Every source, both directions, serviced as a host would
    foreach (rows[i]) begin
      step(i, 1'b1);
      rd_chk({8'h0D, rows[i].a}, rows[i].r);
      irq_host_model_i.service({8'h0D, rows[i].a});
      rd_chk({8'h0D, rows[i].a}, 16'h0000);
      step(i, 1'b0);
      rd_chk({8'h0D, rows[i].a}, rows[i].f);
      irq_host_model_i.service({8'h0D, rows[i].a});
    end
    // One flag unmasked, then masked again while still set
    wr(16'h0D0B, 16'hF7FF);
    rd_chk(16'h0D0B, 16'hF7FF);
    step(12, 1'b1);
    chk({15'h0000, irq_pin}, 16'h0000);
    wr(16'h0D0B, 16'hFFFF);
    step(12, 1'b0);
    chk({15'h0000, irq_pin}, 16'h0001);
    rd_chk(16'h0D03, 16'h0800);
    wr(16'h0D0D, 16'hFFFF);
    rd_chk(16'h0D0D, 16'h0000);
    wr(16'h0D53, 16'h0000);
    rd_chk(16'h0D53, 16'h0000);
    // An open always-on mask lets the jack rise reach the pin
    step(21, 1'b1);
    chk({15'h0000, irq_pin}, 16'h0000);
    // Second reset in mid-run restores flags and masks
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rd_chk(16'h0D03, 16'h0000);
    rd_chk(16'h0D53, 16'h00FC);
    rd_chk(16'h0D0B, 16'hFFFF);
    report_and_stop;
  end
endmodule
